// ===== inc/sync_activity_pkg.sv
/*
 Constants shared by the sync activity and event flag logic: register
 indices, field positions, reset values and detector timing.
 Assumes a 100 MHz register clock and a 32-bit AXI4-Lite slave port.
*/
// Notes on behaviour
// - Channel 2/3 activity readable as one byte
// - Flags sticky until host writes one
// - Bits 0-3 set on channel sync change
// - Bit 4 set when selected sync disrupted
// - Bit 5 set when selected timing settles
// - Bit 6 set on every vertical sync
// - Bit 7 set when phase tuning finishes
// - Mask bits 0-3 gate channel interrupts
// - Mask bit 4 gates disruption interrupt
// - Mask bit 5 gates settled interrupt
// - Mask bit 6 gates vertical sync interrupt
// - Mask bit 7 gates phase tuning interrupt
// - Horizontal activity needs periodic, consistent, above 1kHz
// - Vertical activity needs periodic, consistent, above 20Hz
// - Green sync code 00, 01, 10
package sync_activity_pkg;
   localparam int AXI_ADDR_W = 8;
   localparam int IDX_W = 6;
   // Register indices; the byte address is four times the index.
   localparam logic [IDX_W-1:0] IDX_ACTIVITY = 6'h03;
   localparam logic [IDX_W-1:0] IDX_FLAGS = 6'h04;
   localparam logic [IDX_W-1:0] IDX_MASK = 6'h05;
   localparam logic [7:0] MASK_RST = 8'hFF;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Activity byte layout per channel, channel 3 at +CH_STRIDE.
   localparam int ACT_H = 0;
   localparam int ACT_V = 1;
   localparam int ACT_G = 2;
   localparam int CH_STRIDE = 4;
   localparam logic [1:0] GREEN_NONE = 2'h0;
   localparam logic [1:0] GREEN_RANDOM = 2'h1;
   localparam logic [1:0] GREEN_PERIODIC = 2'h2;
   // Event flag positions.
   localparam int CHAN0_SYNC_EVENT = 0;
   localparam int FLAG_DISRUPTED = 4;
   localparam int FLAG_SETTLED = 5;
   localparam int FLAG_VSYNC = 6;
   localparam int PHASE_TUNE_DONE_FLAG = 7;
   // Detector timing: a whole period must be shorter than this.
   localparam int unsigned CLK_HZ = 100_000_000;
   localparam int unsigned HS_MIN_HZ = 1000;
   localparam int unsigned VS_MIN_HZ = 20;
   localparam int unsigned HS_TIMEOUT_CYC = CLK_HZ / HS_MIN_HZ;
   localparam int unsigned VS_TIMEOUT_CYC = CLK_HZ / VS_MIN_HZ;
   localparam int unsigned PHASE_TOL_CYC = 4;
endpackage : sync_activity_pkg

// ===== inc/flag_if.sv
/*
 Carrier between the register front end and the event flag bank.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface flag_if;
   logic [7:0] set;
   logic [7:0] clr;
   logic [7:0] mask;
   logic [7:0] flags;
   logic irq;
   modport bank (input set, input clr, input mask,
                 output flags, output irq);
   modport ctrl (output set, output clr, output mask,
                 input flags, input irq);
endinterface : flag_if

// ===== design/sync_activity_detector.sv
/*
 Activity detector for one sync input: reports transitions seen and a
 periodic signal with steady high and low times and a short period.
 Assumes an asynchronous pin; it is synchronised here.
*/
`timescale 1ns/1ps
module sync_activity_detector #(
   parameter int unsigned TIMEOUT = 100000,
   parameter int unsigned TOL = 4
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic sync_i,
   output logic seen_o,
   output logic periodic_o
);
   localparam int CW = $clog2(TIMEOUT + 1);
   typedef logic [CW-1:0] cnt_t;
   localparam cnt_t TMO = cnt_t'(TIMEOUT);

   function automatic logic near(cnt_t a, cnt_t b);
      cnt_t d;
      d = (a > b) ? a - b : b - a;
      return d <= cnt_t'(TOL);
   endfunction : near

   logic [2:0] s_q, s_d;
   cnt_t ph_q, ph_d, per_q, per_d, hi_q, hi_d, lo_q, lo_d;
   logic hi_ok_q, hi_ok_d, lo_ok_q, lo_ok_d;
   logic seen_q, seen_d, per_ok_q, per_ok_d;
   logic edge_s, rise_s;

   always_comb begin
      s_d = {s_q[1:0], sync_i};
      edge_s = s_q[1] ^ s_q[2];
      rise_s = s_q[1] & ~s_q[2];
      ph_d = (ph_q == TMO) ? ph_q : ph_q + cnt_t'(1);
      per_d = (per_q == TMO) ? per_q : per_q + cnt_t'(1);
      hi_d = hi_q;
      lo_d = lo_q;
      hi_ok_d = hi_ok_q;
      lo_ok_d = lo_ok_q;
      seen_d = seen_q;
      per_ok_d = per_ok_q;
      // no rise for a whole period drops the verdict.
      if (per_q == TMO) begin
         per_ok_d = 1'b0;
         hi_ok_d = 1'b0;
         lo_ok_d = 1'b0;
      end
      // Seen lapses on quiet time, so a lone edge after idle still counts.
      if (ph_q == TMO) begin
         seen_d = 1'b0;
      end
      if (edge_s) begin
         ph_d = '0;
         seen_d = 1'b1;
         if (rise_s) begin
            lo_d = ph_q;
            lo_ok_d = near(ph_q, lo_q);
         end else begin
            hi_d = ph_q;
            hi_ok_d = near(ph_q, hi_q);
         end
      end
      if (rise_s) begin
         per_d = '0;
         per_ok_d = per_q < TMO;
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '0;
         ph_q <= '0;
         per_q <= '0;
         hi_q <= '0;
         lo_q <= '0;
         hi_ok_q <= 1'b0;
         lo_ok_q <= 1'b0;
         seen_q <= 1'b0;
         per_ok_q <= 1'b0;
      end else begin
         s_q <= s_d;
         ph_q <= ph_d;
         per_q <= per_d;
         hi_q <= hi_d;
         lo_q <= lo_d;
         hi_ok_q <= hi_ok_d;
         lo_ok_q <= lo_ok_d;
         seen_q <= seen_d;
         per_ok_q <= per_ok_d;
      end
   end

   assign seen_o = seen_q;
   // periodic needs steady phases and period.
   assign periodic_o = seen_q & per_ok_q & hi_ok_q & lo_ok_q;
endmodule : sync_activity_detector

// ===== design/event_flag_bank.sv
/*
 Sticky write-one-to-clear event flags and the masked interrupt.
 Assumes set pulses and clear masks on the same clock.
*/
`timescale 1ns/1ps
module event_flag_bank (
   input wire logic clk_i,
   input wire logic nrst_i,
   flag_if.bank fb
);
   logic [7:0] flags_q, flags_d;
   logic irq_q, irq_d;

   always_comb begin
      // set wins over a clear in the same cycle.
      flags_d = (flags_q & ~fb.clr) | fb.set;
      // a mask bit of one blocks its flag.
      irq_d = |(flags_q & ~fb.mask);
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         flags_q <= '0;
         irq_q <= 1'b0;
      end else begin
         flags_q <= flags_d;
         irq_q <= irq_d;
      end
   end

   assign fb.flags = flags_q;
   assign fb.irq = irq_q;
endmodule : event_flag_bank

// ===== design/sync_activity_interrupt_unit.sv
/*
 Sync activity status for channels 2 and 3, sticky event flags with a
 mask, and the interrupt toward the host, behind an AXI4-Lite slave.
 Assumes event pulses come from logic on clk_i; the sync pins are
 asynchronous and are synchronised inside the detectors.
*/
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module sync_activity_interrupt_unit #(
   parameter int unsigned HS_TIMEOUT_CYC =
      sync_activity_pkg::HS_TIMEOUT_CYC,
   parameter int unsigned VS_TIMEOUT_CYC =
      sync_activity_pkg::VS_TIMEOUT_CYC
) (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [sync_activity_pkg::AXI_ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   output logic awready_o,
   input wire logic [31:0] wdata_i,
   input wire logic [3:0] wstrb_i,
   input wire logic wvalid_i,
   output logic wready_o,
   output logic [1:0] bresp_o,
   output logic bvalid_o,
   input wire logic bready_i,
   input wire logic [sync_activity_pkg::AXI_ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   output logic arready_o,
   output logic [31:0] rdata_o,
   output logic [1:0] rresp_o,
   output logic rvalid_o,
   input wire logic rready_i,
   input wire logic [1:0] hsync_pin_i,
   input wire logic [1:0] vsync_pin_i,
   input wire logic [1:0] green_embedded_sync_i,
   input wire logic [3:0] chan_sync_event_i,
   input wire logic input_disrupted_i,
   input wire logic input_settled_i,
   input wire logic vsync_event_i,
   input wire logic phase_tune_done_i,
   output logic irq_o
);
   import sync_activity_pkg::*;

   flag_if flg ();

   // Detector order per channel: horizontal, vertical, green.
   logic [5:0] raw_s;
   logic [5:0] seen_s;
   logic [5:0] periodic_s;

   logic [7:0] act_q, act_d;
   logic [7:0] mask_q, mask_d;
   logic [7:0] ev_s;
   logic [7:0] clr_s;

   logic awready_q, awready_d;
   logic aw_full_q, aw_full_d;
   logic [IDX_W-1:0] widx_q, widx_d;
   logic wready_q, wready_d;
   logic w_full_q, w_full_d;
   logic [7:0] wbyte_q, wbyte_d;
   logic wlane_q, wlane_d;
   logic bvalid_q, bvalid_d;
   logic [1:0] bresp_q, bresp_d;
   logic do_wr;
   logic aw_take;
   logic w_take;

   logic arready_q, arready_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic [1:0] rresp_q, rresp_d;
   logic ar_take;
   logic [IDX_W-1:0] ridx;

   logic irq_q, irq_d;

   assign raw_s = {green_embedded_sync_i[1], vsync_pin_i[1],
                   hsync_pin_i[1], green_embedded_sync_i[0],
                   vsync_pin_i[0], hsync_pin_i[0]};

   // Vertical inputs get the long timeout, the others the short one.
   genvar k;
   generate
      for (k = 0; k < 6; k++) begin : g_det
         sync_activity_detector #(
            .TIMEOUT((k % 3 == 1) ? VS_TIMEOUT_CYC : HS_TIMEOUT_CYC),
            .TOL(PHASE_TOL_CYC)
         ) u_det (
            .clk_i(clk_i),
            .nrst_i(nrst_i),
            .sync_i(raw_s[k]),
            .seen_o(seen_s[k]),
            .periodic_o(periodic_s[k])
         );
      end
   endgenerate

   always_comb begin
      act_d = '0;
      for (int c = 0; c < 2; c++) begin
         act_d[c*CH_STRIDE+ACT_H] = periodic_s[c*3];
         act_d[c*CH_STRIDE+ACT_V] = periodic_s[c*3+1];
         if (periodic_s[c*3+2]) begin
            act_d[c*CH_STRIDE+ACT_G +: 2] = GREEN_PERIODIC;
         end else if (seen_s[c*3+2]) begin
            act_d[c*CH_STRIDE+ACT_G +: 2] = GREEN_RANDOM;
         end else begin
            act_d[c*CH_STRIDE+ACT_G +: 2] = GREEN_NONE;
         end
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         act_q <= '0;
      end else begin
         act_q <= act_d;
      end
   end

   always_comb begin
      ev_s = '0;
      // channel change pulses set bits 0-3.
      ev_s[CHAN0_SYNC_EVENT +: 4] = chan_sync_event_i;
      // local activity changes on channels 2 and 3.
      for (int c = 0; c < 2; c++) begin
         if (act_d[c*CH_STRIDE +: CH_STRIDE] !=
             act_q[c*CH_STRIDE +: CH_STRIDE]) begin
            ev_s[CHAN0_SYNC_EVENT+2+c] = 1'b1;
         end
      end
      ev_s[FLAG_DISRUPTED] = input_disrupted_i;
      ev_s[FLAG_SETTLED] = input_settled_i;
      ev_s[FLAG_VSYNC] = vsync_event_i;
      ev_s[PHASE_TUNE_DONE_FLAG] = phase_tune_done_i;
   end

   always_comb begin
      clr_s = '0;
      // writing one clears, zero leaves the flag.
      if (do_wr && widx_q == IDX_FLAGS && wlane_q) begin
         clr_s = wbyte_q;
      end
   end

   assign flg.set = ev_s;
   assign flg.clr = clr_s;
   // per-bit mask gates channel flags and the rest alike.
   assign flg.mask = mask_q;

   event_flag_bank u_bank (
      .clk_i(clk_i),
      .nrst_i(nrst_i),
      .fb(flg.bank)
   );

   // Write path: address and data are taken in either order and the
   // write is performed in the first cycle that both are held.
   always_comb begin
      aw_take = awvalid_i & awready_q;
      w_take = wvalid_i & wready_q;
      do_wr = aw_full_q & w_full_q & ~bvalid_q;
      widx_d = aw_take ? awaddr_i[AXI_ADDR_W-1:2] : widx_q;
      wbyte_d = w_take ? wdata_i[7:0] : wbyte_q;
      wlane_d = w_take ? wstrb_i[0] : wlane_q;
      aw_full_d = do_wr ? 1'b0 : (aw_full_q | aw_take);
      w_full_d = do_wr ? 1'b0 : (w_full_q | w_take);
      bvalid_d = do_wr | (bvalid_q & ~bready_i);
      awready_d = ~aw_full_d & ~bvalid_d;
      wready_d = ~w_full_d & ~bvalid_d;
      bresp_d = bresp_q;
      mask_d = mask_q;
      if (do_wr) begin
         bresp_d = RESP_OKAY;
         case (widx_q)
            IDX_ACTIVITY: bresp_d = RESP_OKAY;
            IDX_FLAGS: bresp_d = RESP_OKAY;
            IDX_MASK: begin
               if (wlane_q) begin
                  mask_d = wbyte_q;
               end
            end
            default: bresp_d = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         awready_q <= 1'b0;
         aw_full_q <= 1'b0;
         widx_q <= '0;
         wready_q <= 1'b0;
         w_full_q <= 1'b0;
         wbyte_q <= '0;
         wlane_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
         mask_q <= MASK_RST;
      end else begin
         awready_q <= awready_d;
         aw_full_q <= aw_full_d;
         widx_q <= widx_d;
         wready_q <= wready_d;
         w_full_q <= w_full_d;
         wbyte_q <= wbyte_d;
         wlane_q <= wlane_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
         mask_q <= mask_d;
      end
   end

   // Read path: data is sampled at the address edge, so a flag set in
   // the same cycle shows on the next read.
   always_comb begin
      ar_take = arvalid_i & arready_q;
      ridx = araddr_i[AXI_ADDR_W-1:2];
      rvalid_d = ar_take | (rvalid_q & ~rready_i);
      arready_d = ~rvalid_d;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (ar_take) begin
         rdata_d = '0;
         rresp_d = RESP_OKAY;
         case (ridx)
            // channel 2 and 3 activity byte.
            IDX_ACTIVITY: rdata_d[7:0] = act_q;
            IDX_FLAGS: rdata_d[7:0] = flg.flags;
            IDX_MASK: rdata_d[7:0] = mask_q;
            default: rresp_d = RESP_SLVERR;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else begin
         arready_q <= arready_d;
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // The bank's interrupt is already a flop; this stage keeps the
   // top output on a flop of its own at the cost of one cycle.
   always_comb begin
      // masked flags never reach the pin.
      // phase tuning flag follows its mask too.
      irq_d = flg.irq;
   end

   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= irq_d;
      end
   end

   assign awready_o = awready_q;
   assign wready_o = wready_q;
   assign bresp_o = bresp_q;
   assign bvalid_o = bvalid_q;
   assign arready_o = arready_q;
   assign rdata_o = rdata_q;
   assign rresp_o = rresp_q;
   assign rvalid_o = rvalid_q;
   assign irq_o = irq_q;
endmodule : sync_activity_interrupt_unit

// ===== bench/sync_activity_props.sv
/*
 Concurrent checks on the bus and interrupt ports of the sync unit.
 Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ps
module sync_activity_props (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic [sync_activity_pkg::AXI_ADDR_W-1:0] awaddr_i,
   input wire logic awvalid_i,
   input wire logic awready_o,
   input wire logic wvalid_i,
   input wire logic wready_o,
   input wire logic [1:0] bresp_o,
   input wire logic bvalid_o,
   input wire logic bready_i,
   input wire logic [sync_activity_pkg::AXI_ADDR_W-1:0] araddr_i,
   input wire logic arvalid_i,
   input wire logic arready_o,
   input wire logic [31:0] rdata_o,
   input wire logic [1:0] rresp_o,
   input wire logic rvalid_o,
   input wire logic rready_i,
   input wire logic irq_o
);
   import sync_activity_pkg::*;
   logic [3:0] since_w_q;
   logic [3:0] since_w_d;
   logic mask_wr_q;
   logic mask_wr_d;
   default clocking @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Saturating count since the last write data was taken.
   always_comb begin
      since_w_d = (since_w_q == 4'hF) ? since_w_q : since_w_q + 4'h1;
      if (wvalid_i && wready_o) begin
         since_w_d = 4'h0;
      end
      mask_wr_d = mask_wr_q |
         (awvalid_i & awready_o & (awaddr_i[7:2] == IDX_MASK));
   end
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         since_w_q <= 4'h0;
         mask_wr_q <= 1'b0;
      end else begin
         since_w_q <= since_w_d;
         mask_wr_q <= mask_wr_d;
      end
   end
   a_irq_needs_unmask: assert property ($rose(irq_o) |-> mask_wr_q)
      else $error("irq rose before any mask write");
   a_irq_fall_write: assert property ($fell(irq_o) |-> since_w_q < 4'h5)
      else $error("irq fell without a recent write");
   a_read_resp: assert property (arvalid_i && arready_o |=> rvalid_o &&
      rresp_o == (($past(araddr_i) >= {IDX_ACTIVITY, 2'b00} &&
      $past(araddr_i) <= {IDX_MASK, 2'b11}) ? RESP_OKAY : RESP_SLVERR))
      else $error("read answer late or wrong response");
   a_rdata_upper: assert property (rvalid_o |-> rdata_o[31:8] == 24'h0)
      else $error("read data upper bits set");
   a_rvalid_hold: assert property (rvalid_o && !rready_i |=>
      rvalid_o && $stable(rdata_o))
      else $error("read data dropped or changed");
   a_write_resp: assert property (awvalid_i && awready_o &&
      wvalid_i && wready_o |-> ##2 bvalid_o && bresp_o ==
      (($past(awaddr_i, 2) >= {IDX_ACTIVITY, 2'b00} &&
      $past(awaddr_i, 2) <= {IDX_MASK, 2'b11}) ? RESP_OKAY : RESP_SLVERR))
      else $error("write answer late or wrong response");
   a_bvalid_hold: assert property (bvalid_o && !bready_i |=>
      bvalid_o && $stable(bresp_o))
      else $error("write response dropped or changed");
   a_write_refuse: assert property (bvalid_o |-> !awready_o && !wready_o)
      else $error("write taken while response pending");
   a_read_refuse: assert property (rvalid_o |-> !arready_o)
      else $error("read taken while data pending");
endmodule : sync_activity_props
bind sync_activity_interrupt_unit sync_activity_props u_props (
   .clk_i(clk_i), .nrst_i(nrst_i), .awaddr_i(awaddr_i),
   .awvalid_i(awvalid_i), .awready_o(awready_o), .wvalid_i(wvalid_i),
   .wready_o(wready_o), .bresp_o(bresp_o), .bvalid_o(bvalid_o),
   .bready_i(bready_i), .araddr_i(araddr_i), .arvalid_i(arvalid_i),
   .arready_o(arready_o), .rdata_o(rdata_o), .rresp_o(rresp_o),
   .rvalid_o(rvalid_o), .rready_i(rready_i), .irq_o(irq_o));

// ===== bench/host_irq_monitor.sv
/*
 Host side of the interrupt line: counts each rising edge it services.
 Assumes the line is a level on the same clock.
*/
`timescale 1ns/1ps
module host_irq_monitor (
   input wire logic clk_i,
   input wire logic nrst_i,
   input wire logic irq_i,
   output int rises_o
);
   logic irq_q;
   always @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_q <= 1'b0;
         rises_o <= 0;
      end else begin
         irq_q <= irq_i;
         if (irq_i && !irq_q) begin
            rises_o <= rises_o + 1;
         end
      end
   end
endmodule : host_irq_monitor

// ===== bench/sync_activity_interrupt_unit_tb_top.sv
/*
 Self-checking bench for the sync activity and interrupt unit.
 Assumes short detector timeouts; ch2 and ch3 pins toggle together.
*/
`timescale 1ns/1ps
module sync_activity_interrupt_unit_tb_top;
   import sync_activity_pkg::*;
   logic clk_i, nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
   logic rready_i, dis_i, set_i, vs_i, pt_i, sync_en;
   logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o;
   logic [7:0] awaddr_i, araddr_i;
   logic [31:0] wdata_i, rdata_o, d;
   logic [3:0] wstrb_i, ev_i;
   logic [1:0] bresp_o, rresp_o, hs_i, vp_i, gr_i, r;
   logic [15:0] rnd = 16'h71BA;
   int err_count = 0, n_tests = 0, wd = 0, sc = 0, rises;
   int flags_m, mask_m;
   sync_activity_interrupt_unit #(.HS_TIMEOUT_CYC(64),
      .VS_TIMEOUT_CYC(256)) dut (
      .clk_i(clk_i), .nrst_i(nrst_i), .awaddr_i(awaddr_i),
      .awvalid_i(awvalid_i), .awready_o(awready_o), .wdata_i(wdata_i),
      .wstrb_i(wstrb_i), .wvalid_i(wvalid_i), .wready_o(wready_o),
      .bresp_o(bresp_o), .bvalid_o(bvalid_o), .bready_i(bready_i),
      .araddr_i(araddr_i), .arvalid_i(arvalid_i), .arready_o(arready_o),
      .rdata_o(rdata_o), .rresp_o(rresp_o), .rvalid_o(rvalid_o),
      .rready_i(rready_i), .hsync_pin_i(hs_i), .vsync_pin_i(vp_i),
      .green_embedded_sync_i(gr_i), .chan_sync_event_i(ev_i),
      .input_disrupted_i(dis_i), .input_settled_i(set_i),
      .vsync_event_i(vs_i), .phase_tune_done_i(pt_i), .irq_o(irq_o));
   host_irq_monitor host (.clk_i(clk_i), .nrst_i(nrst_i),
      .irq_i(irq_o), .rises_o(rises));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // Periods of 20 and 100 cycles sit inside their shortened timeouts of 64 and 256 cycles.
   always @(posedge clk_i) begin
      sc <= sync_en ? sc + 1 : 0;
      if (sync_en && sc % 10 == 9) begin
         hs_i <= ~hs_i;
         gr_i <= ~gr_i;
      end
      if (sync_en && sc % 50 == 49) begin
         vp_i <= ~vp_i;
      end
   end
   always @(posedge clk_i) begin
      wd <= wd + 1;
      if (wd == 20000) begin
         err_count++;
         stop_test();
      end
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {1'b0, s[15:1]} ^ (s[0] ? 16'hB400 : 16'h0000);
   endfunction : lfsr
   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] v,
      output logic [1:0] rs);
      logic aw, w, b;
      aw = 1'b0;
      w = 1'b0;
      b = 1'b0;
      awaddr_i <= a;
      wdata_i <= {24'h0, v};
      wstrb_i <= 4'h1;
      awvalid_i <= 1'b1;
      wvalid_i <= 1'b1;
      while (!(aw && w)) begin
         @(negedge clk_i);
         aw = aw | awready_o;
         w = w | wready_o;
         @(posedge clk_i);
         if (aw) awvalid_i <= 1'b0;
         if (w) wvalid_i <= 1'b0;
      end
      // A late ready lets the response be seen waiting.
      repeat (2) @(posedge clk_i);
      bready_i <= 1'b1;
      while (!b) begin
         @(negedge clk_i);
         b = bvalid_o;
         rs = bresp_o;
         @(posedge clk_i);
      end
      bready_i <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [31:0] dv,
      output logic [1:0] rs);
      logic t;
      t = 1'b0;
      araddr_i <= a;
      arvalid_i <= 1'b1;
      while (!t) begin
         @(negedge clk_i);
         t = arready_o;
         @(posedge clk_i);
      end
      arvalid_i <= 1'b0;
      @(posedge clk_i);
      rready_i <= 1'b1;
      t = 1'b0;
      while (!t) begin
         @(negedge clk_i);
         t = rvalid_o;
         dv = rdata_o;
         rs = rresp_o;
         @(posedge clk_i);
      end
      rready_i <= 1'b0;
   endtask : rd
   task automatic cf(input logic [7:0] a, input int e, input string nm);
      rd(a, d, r);
      chk(nm, e, d);
   endtask : cf
   // The level is read mid-cycle, away from the edge that moves it.
   task automatic ci(input string nm, input logic e);
      @(negedge clk_i);
      chk(nm, 32'(e), 32'(irq_o));
      @(posedge clk_i);
   endtask : ci
   task automatic pulse(input logic [7:0] v);
      {pt_i, vs_i, set_i, dis_i, ev_i} <= v;
      @(posedge clk_i);
      {pt_i, vs_i, set_i, dis_i, ev_i} <= 8'h00;
      @(posedge clk_i);
      flags_m = flags_m | v;
   endtask : pulse
   task automatic stop_test();
      $display("checks %0d errors %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test
   initial begin
      {nrst_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = 0;
      {dis_i, set_i, vs_i, pt_i, sync_en, ev_i, wstrb_i} = 0;
      {awaddr_i, araddr_i, wdata_i, hs_i, vp_i, gr_i} = 0;
      flags_m = 0;
      mask_m = 8'hFF;
      repeat (3) @(posedge clk_i);
      nrst_i <= 1'b1;
      @(posedge clk_i);
      cf(8'h14, mask_m, "mask reset");
      cf(8'h10, 0, "flags reset");
      cf(8'h0C, 0, "activity reset");
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         pulse(8'h01 << i);
         cf(8'h10, flags_m, "flag set");
         ci("irq masked", 1'b0);
         wr(8'h14, ~(8'h01 << i), r);
         repeat (4) @(posedge clk_i);
         ci("irq open", 1'b1);
         wr(8'h10, 8'h00, r);
         cf(8'h10, flags_m, "flag kept");
         wr(8'h10, 8'h01 << i, r);
         flags_m = 0;
         repeat (4) @(posedge clk_i);
         ci("irq cleared", 1'b0);
         wr(8'h14, 8'hFF, r);
      end
      $display("test events done");
      for (int k = 0; k < 4; k++) begin
         rnd = lfsr(rnd);
         pulse(rnd[7:0]);
         cf(8'h10, flags_m, "random flags");
         wr(8'h10, 8'hFF, r);
         flags_m = 0;
         cf(8'h10, 0, "clear all");
      end
      rd(8'h3C, d, r);
      chk("unmapped rresp", 32'(RESP_SLVERR), 32'(r));
      wr(8'h3C, 8'h00, r);
      chk("unmapped bresp", 32'(RESP_SLVERR), 32'(r));
      wr(8'h0C, 8'hFF, r);
      cf(8'h0C, 0, "ro kept");
      $display("test access done");
      sync_en <= 1'b1;
      repeat (600) @(posedge clk_i);
      cf(8'h0C, 32'hBB, "activity on");
      cf(8'h10, 8'h0C, "chan flags");
      sync_en <= 1'b0;
      repeat (400) @(posedge clk_i);
      cf(8'h0C, 0, "activity off");
      gr_i <= ~gr_i;
      repeat (8) @(posedge clk_i);
      cf(8'h0C, 32'h44, "green random");
      chk("irq rises", 8, rises);
      $display("test activity done");
      stop_test();
   end
endmodule : sync_activity_interrupt_unit_tb_top
